/* design/gpio_irq_defs.vh */
// constants for the external interrupt, wakeup filter and debug pin block
// assumes inclusion by bare name from design files only
`ifndef GPIO_IRQ_DEFS_VH
`define GPIO_IRQ_DEFS_VH

// ****************************************
// register byte offsets (low 16 bits of paddr)
// ****************************************
`define OFS_PENDING 16'ha814
`define OFS_CFG_A 16'ha860
`define OFS_CFG_B 16'ha864
`define OFS_CFG_C 16'ha868
`define OFS_CFG_D 16'ha86c
`define OFS_DBG_CFG 16'hbc00
`define OFS_DBG_STAT 16'hbc04
`define OFS_WAKE_FILT 16'hbc0c
`define OFS_SEL_C 16'hbc14
`define OFS_SEL_D 16'hbc18
`define OFS_IRQ_MASK 16'hbc40

// ****************************************
// field positions and reset values
// ****************************************
`define CFG_FILT_BIT 8
`define CFG_TRIG_HI 7
`define CFG_TRIG_LO 5
`define DBG_BLOCK_BIT 5
`define DBG_REGOFF_BIT 4
`define DBG_RSVD_BIT 3
`define STAT_BOOT_BIT 3
`define STAT_FORCED_BIT 1
`define STAT_SWIRE_BIT 0
`define DBG_CFG_RESET 2'h1
`define SEL_C_RESET 5'h0f
`define SEL_D_RESET 5'h10
`define SEL_LAST_PIN 5'h17
`define BOOT_SETTLE 2'h3

// ****************************************
// trigger modes
// ****************************************
`define TRIG_OFF 3'h0
`define TRIG_RISE 3'h1
`define TRIG_FALL 3'h2
`define TRIG_BOTH 3'h3
`define TRIG_HIGH 3'h4
`define TRIG_LOW 3'h5

`endif

/* design/glitch_filter.v */
// stability filter: output follows input once stable for a number of samples
// assumes the input is already synchronised to pclk
`timescale 1ns/1ps
module glitch_filter #(
    parameter STABLE_CYCLES = 4
) (
    pclk,
    presetn,
    raw_in,
    filt_out
);
    input wire pclk;
    input wire presetn;
    input wire raw_in;
    output reg filt_out;

    reg [7:0] count_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 8'h00;
            filt_out <= 1'b0;
        end else if (raw_in == filt_out) begin
            count_q <= 8'h00;
        end else if (count_q == STABLE_CYCLES[7:0] - 8'h01) begin
            filt_out <= raw_in;
            count_q <= 8'h00;
        end else begin
            count_q <= count_q + 8'h01;
        end
    end
endmodule // glitch_filter

/* design/gpio_ext_irq_wake_debug_cfg.v */
// external pin interrupt lines, wakeup filtering and debug pin controls
// assumes an apb master on pclk; all pin inputs are asynchronous to pclk
`timescale 1ns/1ps
`include "gpio_irq_defs.vh"

// Notes on behaviour
// - wake filter bit 3 filters line d wake
// - bits 2 and 1 filter serial wake pins
// - bit 0 filters port wake monitor sources
// - five bit pin index, 0x18-0x1f reserved
// - config bit 8 filters line before detection
// - trigger 0 off, 1 rise, 2 fall, 3 both
// - trigger 4 high level, 5 low level
// - pending bits 0..3 for lines a..d
// - block bit stops inactive debug override
// - bit 4 disables regulator pin override
// - status bit 3 holds sampled boot pin
// - status bit 1 shows forced debugger
// - status bit 0 shows serial wire enabled
module gpio_ext_irq_wake_debug_cfg #(
    parameter FILTER_CYCLES = 4
) (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    pin_in,
    ext_line_a,
    ext_line_b,
    port_wake_in,
    serial1_wake_in,
    serial2_wake_in,
    boot_select_n,
    debugger_forced_in,
    serial_wire_active_in,
    debug_rsvd_in,
    debug_active_in,
    line_c_out,
    line_d_out,
    line_d_wake,
    serial1_wake,
    serial2_wake,
    port_wake,
    debug_override_en,
    regulator_override_en,
    irq
);
    input wire pclk;
    input wire presetn;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [15:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    input wire [23:0] pin_in;
    input wire ext_line_a;
    input wire ext_line_b;
    input wire port_wake_in;
    input wire serial1_wake_in;
    input wire serial2_wake_in;
    input wire boot_select_n;
    input wire debugger_forced_in;
    input wire serial_wire_active_in;
    input wire debug_rsvd_in;
    input wire debug_active_in;
    output reg line_c_out;
    output reg line_d_out;
    output wire line_d_wake;
    output wire serial1_wake;
    output wire serial2_wake;
    output wire port_wake;
    output reg debug_override_en;
    output reg regulator_override_en;
    output wire irq;

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam NSYNC = 34;
    wire [NSYNC-1:0] async_in;
    reg [NSYNC-1:0] meta_q;
    reg [NSYNC-1:0] sync_q;
    assign async_in = {serial_wire_active_in, debugger_forced_in, boot_select_n,
        debug_rsvd_in, debug_active_in, serial2_wake_in, serial1_wake_in,
        port_wake_in, ext_line_b, ext_line_a, pin_in};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {NSYNC{1'b0}};
            sync_q <= {NSYNC{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    wire [23:0] pins_s = sync_q[23:0];
    wire line_a_s = sync_q[24];
    wire line_b_s = sync_q[25];
    wire port_wake_s = sync_q[26];
    wire serial1_wake_s = sync_q[27];
    wire serial2_wake_s = sync_q[28];
    wire debug_active_s = sync_q[29];
    wire debug_rsvd_s = sync_q[30];
    wire boot_n_s = sync_q[31];
    wire forced_s = sync_q[32];
    wire swire_s = sync_q[33];

    // ****************************************
    // registers
    // ****************************************
    reg [8:0] cfg_q [0:3];
    reg [4:0] sel_c_q;
    reg [4:0] sel_d_q;
    reg [3:0] wake_filt_q;
    reg [1:0] dbg_cfg_q;
    reg [3:0] pending_q;
    reg [3:0] mask_q;
    reg boot_sampled_q;
    reg [1:0] boot_wait_q;

    // ****************************************
    // pin routing and line filters
    // ****************************************
    // reserved codes route nothing, so the line reads low
    function pick_pin;
        input [23:0] pins;
        input [4:0] sel;
        begin
            if (sel > `SEL_LAST_PIN)
                pick_pin = 1'b0;
            else
                pick_pin = pins[sel];
        end
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_c_out <= 1'b0;
            line_d_out <= 1'b0;
        end else begin
            line_c_out <= pick_pin(pins_s, sel_c_q);
            line_d_out <= pick_pin(pins_s, sel_d_q);
        end
    end

    wire [3:0] raw_line = {line_d_out, line_c_out, line_b_s, line_a_s};
    wire [3:0] filt_line;
    wire [3:0] used_line;
    wire [3:0] wake_raw = {line_d_out, serial2_wake_s, serial1_wake_s, port_wake_s};
    wire [3:0] wake_filt;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_filt
            glitch_filter #(
                .STABLE_CYCLES(FILTER_CYCLES)
            ) u_line_filt (
                .pclk(pclk),
                .presetn(presetn),
                .raw_in(raw_line[g]),
                .filt_out(filt_line[g])
            );
            assign used_line[g] = cfg_q[g][`CFG_FILT_BIT] ? filt_line[g] : raw_line[g];
            glitch_filter #(
                .STABLE_CYCLES(FILTER_CYCLES)
            ) u_wake_filt (
                .pclk(pclk),
                .presetn(presetn),
                .raw_in(wake_raw[g]),
                .filt_out(wake_filt[g])
            );
        end
    endgenerate

    assign line_d_wake = wake_filt_q[3] ? wake_filt[3] : wake_raw[3];
    assign serial2_wake = wake_filt_q[2] ? wake_filt[2] : wake_raw[2];
    assign serial1_wake = wake_filt_q[1] ? wake_filt[1] : wake_raw[1];
    assign port_wake = wake_filt_q[0] ? wake_filt[0] : wake_raw[0];

    // ****************************************
    // trigger detection
    // ****************************************
    reg [3:0] prev_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prev_q <= 4'h0;
        else
            prev_q <= used_line;
    end

    // reserved modes 6 and 7 never trigger
    function trig_hit;
        input [2:0] mode;
        input cur;
        input prev;
        begin
            case (mode)
                `TRIG_RISE: trig_hit = cur & ~prev;
                `TRIG_FALL: trig_hit = ~cur & prev;
                `TRIG_BOTH: trig_hit = cur ^ prev;
                `TRIG_HIGH: trig_hit = cur;
                `TRIG_LOW: trig_hit = ~cur;
                default: trig_hit = 1'b0;
            endcase
        end
    endfunction

    reg [3:0] hit;
    integer i;
    always @* begin
        hit = 4'h0;
        for (i = 0; i < 4; i = i + 1)
            hit[i] = trig_hit(cfg_q[i][`CFG_TRIG_HI:`CFG_TRIG_LO], used_line[i], prev_q[i]);
    end

    // ****************************************
    // apb slave: zero wait states
    // ****************************************
    wire wr_en = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    reg mapped;

    always @* begin
        case (paddr)
            `OFS_PENDING, `OFS_CFG_A, `OFS_CFG_B, `OFS_CFG_C, `OFS_CFG_D,
            `OFS_DBG_CFG, `OFS_DBG_STAT, `OFS_WAKE_FILT, `OFS_SEL_C,
            `OFS_SEL_D, `OFS_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire [3:0] clr = (wr_en && paddr == `OFS_PENDING) ? pwdata[3:0] : 4'h0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q[0] <= 9'h000;
            cfg_q[1] <= 9'h000;
            cfg_q[2] <= 9'h000;
            cfg_q[3] <= 9'h000;
            sel_c_q <= `SEL_C_RESET;
            sel_d_q <= `SEL_D_RESET;
            wake_filt_q <= 4'h0;
            dbg_cfg_q <= `DBG_CFG_RESET;
            pending_q <= 4'h0;
            mask_q <= 4'h0;
        end else begin
            pending_q <= (pending_q & ~clr) | hit;
            if (wr_en) begin
                case (paddr)
                    `OFS_CFG_A: cfg_q[0] <= pwdata[8:0];
                    `OFS_CFG_B: cfg_q[1] <= pwdata[8:0];
                    `OFS_CFG_C: cfg_q[2] <= pwdata[8:0];
                    `OFS_CFG_D: cfg_q[3] <= pwdata[8:0];
                    `OFS_SEL_C: sel_c_q <= pwdata[4:0];
                    `OFS_SEL_D: sel_d_q <= pwdata[4:0];
                    `OFS_WAKE_FILT: wake_filt_q <= pwdata[3:0];
                    `OFS_DBG_CFG: dbg_cfg_q <= pwdata[`DBG_BLOCK_BIT:`DBG_REGOFF_BIT];
                    `OFS_IRQ_MASK: mask_q <= pwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // boot pin level taken at the first edge after release, read once it has
    // crossed both synchroniser stages
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_wait_q <= 2'h0;
            boot_sampled_q <= 1'b0;
        end else if (boot_wait_q != `BOOT_SETTLE) begin
            boot_wait_q <= boot_wait_q + 2'h1;
            if (boot_wait_q == `BOOT_SETTLE - 2'h1)
                boot_sampled_q <= ~boot_n_s;
        end
    end

    // ****************************************
    // debug override controls
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_override_en <= 1'b1;
            regulator_override_en <= 1'b0;
        end else begin
            // an already active debug link keeps its override
            debug_override_en <= ~dbg_cfg_q[1] | debug_active_s;
            regulator_override_en <= ~dbg_cfg_q[0];
        end
    end

    assign irq = |(pending_q & mask_q);

    // ****************************************
    // read mux
    // ****************************************
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        case (paddr)
            `OFS_PENDING: rd_word[3:0] = pending_q;
            `OFS_CFG_A: rd_word[8:0] = cfg_q[0];
            `OFS_CFG_B: rd_word[8:0] = cfg_q[1];
            `OFS_CFG_C: rd_word[8:0] = cfg_q[2];
            `OFS_CFG_D: rd_word[8:0] = cfg_q[3];
            `OFS_SEL_C: rd_word[4:0] = sel_c_q;
            `OFS_SEL_D: rd_word[4:0] = sel_d_q;
            `OFS_WAKE_FILT: rd_word[3:0] = wake_filt_q;
            `OFS_IRQ_MASK: rd_word[3:0] = mask_q;
            `OFS_DBG_CFG: begin
                rd_word[`DBG_BLOCK_BIT:`DBG_REGOFF_BIT] = dbg_cfg_q;
                rd_word[`DBG_RSVD_BIT] = debug_rsvd_s;
            end
            `OFS_DBG_STAT: begin
                rd_word[`STAT_BOOT_BIT] = boot_sampled_q;
                rd_word[`STAT_FORCED_BIT] = forced_s;
                rd_word[`STAT_SWIRE_BIT] = swire_s;
            end
            default: ;
        endcase
    end

    // read data is taken from flops at the setup edge, so it stands for the
    // whole access phase and reads zero at every other time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= rd_word;
        else
            prdata <= 32'h00000000;
    end
endmodule // gpio_ext_irq_wake_debug_cfg

/* test/gpio_irq_checker.sv */
// port checker for the external interrupt, wakeup filter and debug pin block
// assumes it is bound to the design top and sees only its ports
`timescale 1ns/1ps
module gpio_irq_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_wire_active_in,
    input wire logic debugger_forced_in,
    input wire logic irq,
    input wire logic regulator_override_en
);
    // ****
    // helpers
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic rd;
    logic mapped;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = paddr inside {16'ha814, 16'ha860, 16'ha864, 16'ha868, 16'ha86c,
        16'hbc00, 16'hbc04, 16'hbc0c, 16'hbc14, 16'hbc18, 16'hbc40};
    // status inputs pass a synchroniser, so only a steady input is compared
    sequence swire_steady;
        serial_wire_active_in [*6];
    endsequence
    sequence forced_steady;
        debugger_forced_in [*6];
    endsequence
    // ****
    // assertions
    // ****
    a_zero_wait: assert property (acc |-> pready) else $error("access not ready");
    a_unmapped_err: assert property (acc |-> pslverr == !mapped) else $error("bad slverr");
    a_idle_quiet: assert property (!rd |-> prdata == 32'h0) else $error("prdata not zero");
    a_select_width: assert property (rd && paddr == 16'hbc14 |-> prdata[31:5] == 27'h0)
        else $error("select reserved bits set");
    a_config_width: assert property (rd && paddr[15:4] == 12'ha86 |-> prdata[31:9] == 23'h0)
        else $error("config reserved bits set");
    a_swire_seen: assert property (swire_steady ##0 (rd && paddr == 16'hbc04) |-> prdata[0])
        else $error("serial wire status lost");
    a_forced_seen: assert property (forced_steady ##0 (rd && paddr == 16'hbc04) |-> prdata[1])
        else $error("forced debugger status lost");
    a_mask_silent: assert property (acc && pwrite && paddr == 16'hbc40 && pwdata[3:0] == 4'h0
        |=> !irq) else $error("irq with empty mask");
    a_reg_override: assert property (acc && pwrite && paddr == 16'hbc00 && pwdata[4]
        |=> ##[0:1] !regulator_override_en) else $error("regulator override not off");
endmodule // gpio_irq_checker

bind gpio_ext_irq_wake_debug_cfg gpio_irq_checker i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_wire_active_in(serial_wire_active_in), .debugger_forced_in(debugger_forced_in),
    .regulator_override_en(regulator_override_en));

/* test/ext_pin_model.sv */
// external pins and wake sources seen by the block
// assumes the bench changes want just after a rising edge
`timescale 1ns/1ps
module ext_pin_model (
    input wire logic pclk,
    input wire logic [28:0] want,
    output logic [23:0] pin_in,
    output logic ext_line_a,
    output logic ext_line_b,
    output logic port_wake_in,
    output logic serial1_wake_in,
    output logic serial2_wake_in
);
    // ****
    // pin levels
    // ****
    // pins are always driven, so an idle source keeps its last level
    logic [28:0] lvl = 29'h0;
    always @(posedge pclk) lvl <= want;
    assign {serial2_wake_in, serial1_wake_in, port_wake_in, ext_line_b, ext_line_a, pin_in} = lvl;
endmodule // ext_pin_model

/* test/gpio_ext_irq_wake_debug_cfg_tb_top.sv */
// self-checking bench for the external interrupt, wakeup and debug pin block
// assumes the checker is bound and the pin model drives the external pins
`timescale 1ns/1ps
module gpio_ext_irq_wake_debug_cfg_tb_top;
    localparam logic [15:0] pend = 16'ha814, cfga = 16'ha860, dbg = 16'hbc00, wake = 16'hbc0c;
    localparam logic [15:0] selc = 16'hbc14, seld = 16'hbc18, mask = 16'hbc40;
    localparam logic [15:0] ra [11] = '{pend, cfga, 16'ha864, 16'ha868, 16'ha86c, dbg,
        16'hbc04, wake, selc, seld, mask};
    localparam logic [31:0] rv [11] = '{0, 0, 0, 0, 0, 32'h10, 32'hb, 0, 32'hf, 32'h10, 0};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, irq, line_c_out, line_d_out, dbg_en, reg_en, seen_clr = 0, e;
    logic boot_select_n = 0, forced = 1, swire = 1, rsvd = 0, active = 0;
    logic [23:0] pin_in;
    logic [28:0] want = 0;
    logic [3:0] wk, seen = 0;
    logic pa, pb, pw, s1, s2;
    logic [32:0] q[$];
    int num_errors = 0, checks = 0, rc;
    always #10 pclk = ~pclk;
    ext_pin_model i_pins (.pclk(pclk), .want(want), .pin_in(pin_in), .ext_line_a(pa),
        .ext_line_b(pb), .port_wake_in(pw), .serial1_wake_in(s1), .serial2_wake_in(s2));
    gpio_ext_irq_wake_debug_cfg #(.FILTER_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .ext_line_a(pa),
        .ext_line_b(pb), .port_wake_in(pw), .serial1_wake_in(s1), .serial2_wake_in(s2),
        .boot_select_n(boot_select_n), .debugger_forced_in(forced),
        .serial_wire_active_in(swire), .debug_rsvd_in(rsvd), .debug_active_in(active),
        .line_c_out(line_c_out), .line_d_out(line_d_out), .line_d_wake(wk[3]),
        .serial2_wake(wk[2]), .serial1_wake(wk[1]), .port_wake(wk[0]),
        .debug_override_en(dbg_en), .regulator_override_en(reg_en), .irq(irq));
    // ****
    // tasks
    // ****
    task automatic check(input logic [32:0] s, input logic [32:0] x);
        checks++;
        if (s !== x) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, s, x);
        end
    endtask
    task automatic conclude;
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [32:0] x);
        int n;
        q.push_back(x);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            $display("ERROR %0t: no ready", $time);
            conclude();
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x);
        apb(0, a, 0, {1'b0, x});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1, a, d, 33'h0);
    endtask
    task automatic idle(input int n);
        psel <= 0;
        penable <= 0;
        repeat (n) @(posedge pclk);
    endtask
    // every completed transfer is compared with the oldest note
    always @(posedge pclk) if (psel && penable && pready) check({pslverr, prdata}, q.pop_front());
    always @(posedge pclk) seen <= seen_clr ? 4'h0 : seen | wk;
    // ****
    // main sequence
    // ****
    initial begin
        rc = $urandom(32'hc4bb);
        rc = $urandom % 24;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        boot_select_n <= 1;
        @(posedge pclk);
        foreach (ra[i]) rd(ra[i], rv[i]);
        apb(1, 16'ha818, 32'hf, {1'b1, 32'h0});
        apb(0, 16'ha818, 0, {1'b1, 32'h0});
        for (int m = 0; m < 8; m++) begin
            wr(cfga, m << 5);
            for (int l = 1; l >= 0; l--) begin
                wr(pend, 32'hf);
                want[24] <= l[0];
                idle(12);
                e = l ? m inside {1, 3, 4, 5} : m inside {2, 3, 4, 5};
                rd(pend, {31'h0, e});
            end
        end
        for (int f = 0; f < 3; f++) begin
            wr(cfga, ((f > 0) << 8) | 32'h20);
            wr(pend, 32'hf);
            want[24] <= 1;
            idle(f == 2 ? 8 : 2);
            want[24] <= 0;
            idle(12);
            rd(pend, {31'h0, f != 1});
        end
        wr(cfga, 0);
        wr(selc, rc);
        wr(seld, 32'h18);
        for (int i = 1; i < 4; i++) wr(16'(cfga + 4 * i), 32'h80);
        want <= {5'h2, 24'hffffff};
        idle(8);
        wr(pend, 32'hf);
        idle(8);
        rd(pend, 32'h6);
        check({31'h0, line_d_out, line_c_out}, 33'h1);
        want[23:0] <= ~(24'h1 << rc);
        wr(mask, 32'h2);
        idle(8);
        check({31'h0, line_d_out, line_c_out}, 33'h0);
        check({32'h0, irq}, 33'h1);
        wr(mask, 32'h4);
        idle(2);
        check({32'h0, irq}, 33'h1);
        wr(pend, 32'h4);
        wr(mask, 32'h0);
        idle(2);
        check({32'h0, irq}, 33'h0);
        wr(seld, rc);
        want <= 0;
        idle(8);
        for (int b = 0; b < 5; b++) begin
            wr(wake, b < 4 ? 32'h1 << b : 32'h0);
            seen_clr <= 1;
            idle(1);
            seen_clr <= 0;
            want <= {3'h7, 2'h0, 24'h1 << rc};
            idle(2);
            want <= 0;
            idle(14);
            check({29'h0, seen}, {29'h0, 4'hf & ~(4'h1 << b)});
        end
        rsvd <= 1;
        idle(4);
        rd(dbg, 32'h18);
        wr(dbg, 32'h28);
        idle(4);
        check({31'h0, dbg_en, reg_en}, 33'h1);
        active <= 1;
        idle(4);
        check({31'h0, dbg_en, reg_en}, 33'h3);
        wr(dbg, 32'h18);
        idle(4);
        check({31'h0, dbg_en, reg_en}, 33'h2);
        rd(dbg, 32'h18);
        idle(2);
        conclude();
    end
endmodule // gpio_ext_irq_wake_debug_cfg_tb_top
